// ===== pkg/adc_ctl_pkg.sv
// constants shared by the converter control block and its host bridge
package adc_ctl_pkg;
  // link register indices
  localparam logic [1:0] REG_CTL_ONE = 2'h0;
  localparam logic [1:0] REG_CTL_TWO = 2'h1;
  localparam logic [1:0] REG_RESULT = 2'h2;
  // converter_control_one fields
  localparam int PEND_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int START_BIT = 5;
  localparam int REF_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 4;
  // converter_control_two fields
  localparam int STROBE_EN_BIT = 4;
  localparam int DIV_LSB = 2;
  localparam int ISRC_BIT = 1;
  localparam int GAIN_BIT = 0;
  localparam logic [7:0] CTL_ONE_RST = 8'h00;
  localparam logic [7:0] CTL_TWO_RST = 8'h00;
  localparam logic [7:0] RESULT_RST = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int START_DELAY_NS = 1000;
  localparam int CONV_CYCLE_NS = 1000;
  localparam int START_DELAY_CYC =
    (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYCLE_CYC = CONV_CYCLE_NS / CLK_PERIOD_NS;
  localparam int CONV_BITS = 8;
  localparam int CNT_W = 13;
  // wishbone byte addresses of the host bridge
  localparam logic [7:0] WB_CTL_ONE = 8'h00;
  localparam logic [7:0] WB_CTL_TWO = 8'h04;
  localparam logic [7:0] WB_RESULT = 8'h08;
  localparam logic [7:0] WB_IRQ_STAT = 8'h0c;
  localparam logic [7:0] WB_IRQ_CLR = 8'h10;
  localparam logic [7:0] WB_IRQ_EN = 8'h14;
  localparam logic [7:0] IRQ_RST = 8'h00;
  // host interrupt status bits
  localparam int EV_CONV_IRQ = 0;
  localparam int EV_IDLE = 1;

  // clock cycles of one divided conversion clock period
  function automatic logic [CNT_W-1:0] tick_cycles(input logic [1:0] div);
    logic [CNT_W-1:0] base;
    base = CNT_W'(CONV_CYCLE_CYC);
    return base << div;
  endfunction
endpackage

// ===== pkg/adc_link_if.sv
// register link between the host bridge and the converter control block
interface adc_link_if;
  logic [1:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  logic busy;

  modport device (input addr, wr, rd, wdata, output rdata, irq, busy);
  modport host (output addr, wr, rd, wdata, input rdata, irq, busy);
endinterface

// ===== design/adc_conversion_control.sv
// converter control registers, trigger logic and conversion sequencer
// Operation
// RULE_01 - pending flag sets when result is latched
// RULE_02 - write one keeps pending, zero clears
// RULE_03 - interrupt asserted while enabled and pending
// RULE_04 - software starts by writing start bit
// RULE_05 - busy reads high throughout any conversion
// RULE_06 - writing zero to busy is ignored
// RULE_07 - reference bit picks bandgap or supply
// RULE_08 - channel sampled at trigger, held during conversion
// RULE_09 - channel readback shows last written value
// RULE_10 - strobe mode off: only software starts
// RULE_11 - divider bits divide conversion clock by 1,2,4,8
// RULE_12 - current source bit switches generator on/off
// RULE_13 - gain bit latched at trigger, held steady
// RULE_14 - first control register eight bits, read/write
// RULE_15 - software polls busy, not pending, for completion
// RULE_16 - software uses whole writes keeping pending
// RULE_17 - strobe edge starts conversion, ignored while busy
// RULE_18 - busy at once, sampling after 1 us
// RULE_19 - reset clears both control registers
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module adc_conversion_control
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register link
  adc_link_if.device link,
  // timer strobe and converter data
  input wire logic pwm_conversion_strobe_i,
  input wire logic [7:0] analog_result_i,
  // converter controls
  output logic reference_select_o,
  output logic current_source_enable_o,
  output logic [3:0] channel_applied_o,
  output logic gain_applied_o,
  output logic [1:0] divider_applied_o,
  output logic sample_phase_o,
  output logic bit_tick_o
);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_DELAY = 4'b0010,
    S_CONV = 4'b0100,
    S_TAIL = 4'b1000
  } conv_state_t;

  conv_state_t state_q, state_d;
  logic pend_q, pend_d;
  logic irq_en_q, irq_en_d;
  logic busy_q, busy_d;
  logic ref_q, ref_d;
  logic [3:0] chan_q, chan_d;
  logic strobe_en_q, strobe_en_d;
  logic [1:0] div_q, div_d;
  logic isrc_q, isrc_d;
  logic gain_q, gain_d;
  logic [7:0] result_q, result_d;
  logic [3:0] chan_act_q, chan_act_d;
  logic gain_act_q, gain_act_d;
  logic [1:0] div_act_q, div_act_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] bits_q, bits_d;
  logic strobe_q;
  logic [7:0] rdata_q;
  logic irq_q;

  wire wr_one = link.wr && link.addr == REG_CTL_ONE;
  wire wr_two = link.wr && link.addr == REG_CTL_TWO;
  wire strobe_rise = pwm_conversion_strobe_i && !strobe_q;
  // software start only with strobe mode off and converter idle
  wire sw_start = wr_one && link.wdata[START_BIT] && !strobe_en_q
    && !busy_q; // [RULE_04] [RULE_10]
  wire hw_start = strobe_en_q && strobe_rise && !busy_q; // [RULE_17]
  wire trigger = sw_start || hw_start;
  wire cnt_done = cnt_q == '0;
  wire last_bit = bits_q == 4'(CONV_BITS - 1);
  wire latch_result = state_q == S_CONV && cnt_done && last_bit;
  wire [7:0] ctl_one = {pend_q, irq_en_q, busy_q, ref_q, chan_q};
  wire [7:0] ctl_two = {3'h0, strobe_en_q, div_q, isrc_q, gain_q};

  // register writes and hardware updates
  always_comb
  begin
    irq_en_d = irq_en_q;
    ref_d = ref_q;
    chan_d = chan_q;
    strobe_en_d = strobe_en_q;
    div_d = div_q;
    isrc_d = isrc_q;
    gain_d = gain_q;
    if (wr_one)
    begin
      irq_en_d = link.wdata[IRQ_EN_BIT]; // [RULE_14]
      ref_d = link.wdata[REF_BIT]; // [RULE_07]
      chan_d = link.wdata[CHAN_LSB +: CHAN_W]; // [RULE_09]
    end
    if (wr_two)
    begin
      strobe_en_d = link.wdata[STROBE_EN_BIT];
      div_d = link.wdata[DIV_LSB +: 2];
      isrc_d = link.wdata[ISRC_BIT]; // [RULE_12]
      gain_d = link.wdata[GAIN_BIT];
    end
    // hardware set beats a clearing write in the same cycle
    pend_d = latch_result
      || (pend_q && !(wr_one && !link.wdata[PEND_BIT])); // [RULE_01] [RULE_02]
  end

  // conversion sequencer
  always_comb
  begin
    state_d = state_q;
    busy_d = busy_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    result_d = result_q;
    chan_act_d = chan_act_q;
    gain_act_d = gain_act_q;
    div_act_d = div_act_q;
    unique case (state_q)
      S_IDLE:
        if (trigger)
        begin
          state_d = S_DELAY;
          busy_d = 1'b1; // [RULE_18] [RULE_05]
          cnt_d = CNT_W'(START_DELAY_CYC - 1);
          chan_act_d = chan_d; // [RULE_08]
          gain_act_d = gain_q; // [RULE_13]
          div_act_d = div_q;
        end
      S_DELAY:
        if (cnt_done)
        begin
          state_d = S_CONV; // [RULE_18]
          bits_d = 4'h0;
          cnt_d = tick_cycles(div_act_q) - CNT_W'(1); // [RULE_11]
        end
        else
          cnt_d = cnt_q - CNT_W'(1);
      S_CONV:
        if (cnt_done)
        begin
          cnt_d = tick_cycles(div_act_q) - CNT_W'(1);
          bits_d = bits_q + 4'h1;
          if (last_bit)
          begin
            state_d = S_TAIL;
            result_d = analog_result_i; // [RULE_01]
          end
        end
        else
          cnt_d = cnt_q - CNT_W'(1);
      S_TAIL:
        if (cnt_done)
        begin
          state_d = S_IDLE;
          busy_d = 1'b0; // [RULE_05] [RULE_06]
        end
        else
          cnt_d = cnt_q - CNT_W'(1);
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
      pend_q <= CTL_ONE_RST[PEND_BIT]; // [RULE_19]
      irq_en_q <= CTL_ONE_RST[IRQ_EN_BIT];
      busy_q <= CTL_ONE_RST[START_BIT];
      ref_q <= CTL_ONE_RST[REF_BIT];
      chan_q <= CTL_ONE_RST[CHAN_LSB +: CHAN_W];
      strobe_en_q <= CTL_TWO_RST[STROBE_EN_BIT];
      div_q <= CTL_TWO_RST[DIV_LSB +: 2];
      isrc_q <= CTL_TWO_RST[ISRC_BIT];
      gain_q <= CTL_TWO_RST[GAIN_BIT];
      result_q <= RESULT_RST;
      chan_act_q <= CTL_ONE_RST[CHAN_LSB +: CHAN_W];
      gain_act_q <= CTL_TWO_RST[GAIN_BIT];
      div_act_q <= CTL_TWO_RST[DIV_LSB +: 2];
      cnt_q <= '0;
      bits_q <= 4'h0;
      strobe_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= pend_d;
      irq_en_q <= irq_en_d;
      busy_q <= busy_d;
      ref_q <= ref_d;
      chan_q <= chan_d;
      strobe_en_q <= strobe_en_d;
      div_q <= div_d;
      isrc_q <= isrc_d;
      gain_q <= gain_d;
      result_q <= result_d;
      chan_act_q <= chan_act_d;
      gain_act_q <= gain_act_d;
      div_act_q <= div_act_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      strobe_q <= pwm_conversion_strobe_i;
    end
  end

  // registered read data and interrupt
  wire [7:0] rd_mux = link.addr == REG_CTL_ONE ? ctl_one
    : link.addr == REG_CTL_TWO ? ctl_two
    : link.addr == REG_RESULT ? result_q : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rd_mux;
      irq_q <= irq_en_d && pend_d; // [RULE_03]
    end
  end

  assign link.rdata = rdata_q;
  assign link.irq = irq_q;
  assign link.busy = busy_q;
  assign reference_select_o = ref_q; // [RULE_07]
  assign current_source_enable_o = isrc_q; // [RULE_12]
  assign channel_applied_o = chan_act_q; // [RULE_08]
  assign gain_applied_o = gain_act_q; // [RULE_13]
  assign divider_applied_o = div_act_q; // [RULE_11]
  assign sample_phase_o = state_q == S_CONV && bits_q == 4'h0;
  assign bit_tick_o = state_q == S_CONV && cnt_done;

endmodule // adc_conversion_control

// ===== design/adc_host_bridge.sv
// wishbone bridge that drives the converter register link
module adc_host_bridge
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // register link
  adc_link_if.host link
);

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LINK = 4'b0010,
    H_WAIT = 4'b0100,
    H_ACK = 4'b1000
  } host_state_t;

  host_state_t state_q, state_d;
  logic [7:0] adr_q;
  logic we_q;
  logic sel_q;
  logic [7:0] wdat_q;
  logic [7:0] dat_q;
  logic [7:0] stat_q, stat_d;
  logic [7:0] en_q;
  logic irq_in_q;
  logic busy_in_q;

  wire req = wb_cyc_i && wb_stb_i;
  wire is_link = adr_q == WB_CTL_ONE || adr_q == WB_CTL_TWO
    || adr_q == WB_RESULT;
  wire link_phase = state_q == H_LINK && is_link;
  // software reaches the control registers only by whole writes
  wire wr_link = link_phase && we_q && sel_q
    && adr_q != WB_RESULT; // [RULE_16]
  wire wr_clr = state_q == H_LINK && we_q && sel_q && adr_q == WB_IRQ_CLR;
  wire wr_en = state_q == H_LINK && we_q && sel_q && adr_q == WB_IRQ_EN;
  wire [7:0] events = {6'h00,
    busy_in_q && !link.busy, // [RULE_15]
    link.irq && !irq_in_q};
  wire [7:0] local_rd = adr_q == WB_IRQ_STAT ? stat_q
    : adr_q == WB_IRQ_EN ? en_q : 8'h00;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      H_IDLE:
        if (req)
          state_d = H_LINK;
      H_LINK:
        state_d = H_WAIT;
      H_WAIT:
        state_d = H_ACK;
      H_ACK:
        state_d = H_IDLE;
    endcase
    // new events win over a clear in the same cycle
    stat_d = events | (stat_q & ~(wr_clr ? wdat_q : 8'h00));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= H_IDLE;
      adr_q <= 8'h00;
      we_q <= 1'b0;
      sel_q <= 1'b0;
      wdat_q <= 8'h00;
      dat_q <= 8'h00;
      stat_q <= IRQ_RST;
      en_q <= IRQ_RST;
      irq_in_q <= 1'b0;
      busy_in_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == H_IDLE && req)
      begin
        adr_q <= wb_adr_i;
        we_q <= wb_we_i;
        sel_q <= wb_sel_i[0];
        wdat_q <= wb_dat_i[7:0];
      end
      if (state_q == H_WAIT)
        dat_q <= is_link ? link.rdata : local_rd;
      stat_q <= stat_d;
      if (wr_en)
        en_q <= wdat_q;
      irq_in_q <= link.irq;
      busy_in_q <= link.busy;
    end
  end

  assign link.addr = adr_q[3:2];
  assign link.wr = wr_link; // [RULE_04]
  assign link.rd = link_phase && !we_q;
  assign link.wdata = wdat_q;
  assign wb_ack_o = state_q == H_ACK;
  assign wb_dat_o = {24'h00_0000, dat_q};
  assign irq_o = |(stat_q & en_q);

endmodule // adc_host_bridge

// ===== verification/adc_link_chk.sv
// assertions on the register link between bridge and converter control
module adc_link_chk
  import adc_ctl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic [1:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN_BUSY = 999;
  localparam int MAX_BUSY = 7302;
  logic [7:0] one_q;
  logic [4:0] two_q;
  logic [12:0] cnt_q;
  wire wr_one = wr && addr == REG_CTL_ONE;
  wire wr_two = wr && addr == REG_CTL_TWO;
  wire strobe_mode = two_q[STROBE_EN_BIT];
  wire irq_en = one_q[IRQ_EN_BIT];

  // shadow of written control values and busy length
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      one_q <= 8'h00;
      two_q <= 5'h00;
      cnt_q <= 13'h0000;
    end
    else
    begin
      if (wr_one)
        one_q <= wdata;
      if (wr_two)
        two_q <= wdata[4:0];
      cnt_q <= busy ? cnt_q + 13'h0001 : 13'h0000;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start_req;
    wr_one && wdata[START_BIT] && !busy;
  endsequence
  sequence s_quiet(idx);
    (addr == idx && !wr)[*3];
  endsequence

  AST_RST: assert property (disable iff (1'b0)
    rst_i |=> !busy && !irq && rdata == 8'h00)
    else $error("link not cleared by reset");
  AST_SW_START: assert property (
    s_start_req ##0 !strobe_mode |-> ##[1:2] busy)
    else $error("software start did not set busy");
  AST_NO_SW_START: assert property (
    s_start_req ##0 strobe_mode |=> (!busy)[*2])
    else $error("software start taken in strobe mode");
  AST_BUSY_HOLD: assert property ($rose(busy) |=> busy[*8])
    else $error("busy dropped early");
  AST_BUSY_MIN: assert property ($fell(busy) |-> cnt_q >= MIN_BUSY)
    else $error("conversion too short");
  AST_BUSY_MAX: assert property (busy |-> cnt_q <= MAX_BUSY)
    else $error("conversion too long");
  AST_IRQ_EN: assert property (irq |-> irq_en)
    else $error("irq without enable");
  AST_IRQ_SET: assert property (
    $rose(irq) && $past(irq_en) |-> busy[*8])
    else $error("pending set outside conversion");
  AST_ONE_RB: assert property (
    s_quiet(REG_CTL_ONE) |-> (rdata & 8'h5f) == (one_q & 8'h5f))
    else $error("control one readback wrong");
  AST_TWO_RB: assert property (
    s_quiet(REG_CTL_TWO) |-> rdata == {3'b000, two_q})
    else $error("control two readback wrong");
  AST_RD_WR: assert property (!(rd && wr))
    else $error("link read and write together");
endmodule // adc_link_chk

// ===== verification/adc_conversion_control_tb.sv
// testbench joining host bridge and converter control over the link
module adc_conversion_control_tb
  import adc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic strobe = 1'b0;
  logic [7:0] res = 8'ha5;
  logic [31:0] rdat;
  logic ack, irq, reference_select, isrc, gain;
  logic [3:0] chan;
  logic [1:0] div;
  logic [7:0] q;
  int error_cnt = 0;
  int tests_run = 0;
  int n, m;
  int tick_cnt, phase_cnt, lead_cnt;
  logic sample_phase, bit_tick;
  always #5 clk = ~clk;

  adc_link_if link ();
  adc_conversion_control i_adc_conversion_control (.clk_i(clk),
    .rst_i(rst), .link(link), .pwm_conversion_strobe_i(strobe),
    .analog_result_i(res), .reference_select_o(reference_select),
    .current_source_enable_o(isrc), .channel_applied_o(chan),
    .gain_applied_o(gain), .divider_applied_o(div),
    .sample_phase_o(sample_phase), .bit_tick_o(bit_tick));
  adc_host_bridge i_adc_host_bridge (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .link(link));
  adc_link_chk i_adc_link_chk (.clk_i(clk), .rst_i(rst),
    .addr(link.addr), .wr(link.wr), .wdata(link.wdata),
    .rd(link.rd), .rdata(link.rdata), .irq(link.irq), .busy(link.busy));

  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
      chk("wb ack", 16'h0001, 16'h0000);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {rdat[15:8], q});
  endtask

  task automatic pulse;
    @(posedge clk);
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
  endtask

  // counts busy cycles, bit ticks and sample phase of one conversion
  task automatic watch;
    n = 0;
    m = 0;
    tick_cnt = 0;
    phase_cnt = 0;
    lead_cnt = 0;
    while (m < 8000 && !(n > 0 && link.busy === 1'b0))
    begin
      @(posedge clk);
      m++;
      if (sample_phase === 1'b1)
      begin
        if (phase_cnt == 0)
          lead_cnt = n;
        phase_cnt++;
      end
      if (bit_tick === 1'b1)
        tick_cnt++;
      if (link.busy === 1'b1)
        n++;
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(WB_CTL_ONE, CTL_ONE_RST, "ctl one");
    rdc(WB_CTL_TWO, CTL_TWO_RST, "ctl two");
    $display("test reset done");
    wb(1'b1, WB_CTL_ONE, 8'h73);
    rdc(WB_CTL_ONE, 8'h73, "busy");
    chk("channel", 16'h0003, {12'h000, chan});
    chk("reference", 16'h0001, {15'h0000, reference_select});
    wb(1'b1, WB_CTL_ONE, 8'h59);
    rdc(WB_CTL_ONE, 8'h79, "readback");
    chk("channel held", 16'h0003, {12'h000, chan});
    while (link.busy !== 1'b0) @(posedge clk);
    rdc(WB_CTL_ONE, 8'hd9, "pending");
    rdc(WB_RESULT, 8'ha5, "result");
    chk("link irq", 16'h0001, {15'h0000, link.irq});
    rdc(WB_IRQ_STAT, 8'h03, "status");
    wb(1'b1, WB_IRQ_EN, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    wb(1'b1, WB_IRQ_CLR, 8'h03);
    rdc(WB_IRQ_STAT, 8'h00, "status clear");
    chk("irq clear", 16'h0000, {15'h0000, irq});
    wb(1'b1, WB_CTL_ONE, 8'hd9);
    rdc(WB_CTL_ONE, 8'hd9, "pending kept");
    wb(1'b1, WB_CTL_ONE, 8'h59);
    rdc(WB_CTL_ONE, 8'h59, "pending clear");
    chk("link irq off", 16'h0000, {15'h0000, link.irq});
    rdc(8'h1c, 8'h00, "unmapped");
    $display("test software start done");
    wb(1'b1, WB_CTL_TWO, 8'h17);
    rdc(WB_CTL_TWO, 8'h17, "ctl two");
    chk("current source", 16'h0001, {15'h0000, isrc});
    wb(1'b1, WB_CTL_ONE, 8'h22);
    rdc(WB_CTL_ONE, 8'h02, "no sw start");
    fork
      watch();
      begin
        pulse();
        repeat (20) @(posedge clk);
        chk("gain", 16'h0001, {15'h0000, gain});
        chk("divider", 16'h0001, {14'h0000, div});
        chk("strobe channel", 16'h0002, {12'h000, chan});
        pulse();
        wb(1'b1, WB_CTL_TWO, 8'h12);
        chk("gain held", 16'h0001, {15'h0000, gain});
      end
    join
    m = START_DELAY_CYC + 9 * (CONV_CYCLE_CYC << 1);
    chk("length", 16'h0001, {15'h0000, n >= m - 2 && n <= m + 2});
    chk("ticks", 16'(CONV_BITS), 16'(tick_cnt));
    chk("phase", 16'(CONV_CYCLE_CYC << 1), 16'(phase_cnt));
    chk("lead", 16'(START_DELAY_CYC), 16'(lead_cnt));
    rdc(WB_IRQ_STAT, 8'h02, "status idle");
    chk("irq masked", 16'h0000, {15'h0000, irq});
    $display("test strobe done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdc(WB_CTL_ONE, CTL_ONE_RST, "ctl one again");
    rdc(WB_CTL_TWO, CTL_TWO_RST, "ctl two again");
    rdc(WB_IRQ_STAT, IRQ_RST, "status again");
    wb(1'b1, WB_CTL_TWO, 8'h0c);
    fork
      watch();
      wb(1'b1, WB_CTL_ONE, 8'h25);
    join
    m = START_DELAY_CYC + 9 * (CONV_CYCLE_CYC << 3);
    chk("length slow", 16'(m), 16'(n));
    chk("ticks slow", 16'(CONV_BITS), 16'(tick_cnt));
    chk("phase slow", 16'(CONV_CYCLE_CYC << 3), 16'(phase_cnt));
    chk("lead slow", 16'(START_DELAY_CYC), 16'(lead_cnt));
    chk("channel five", 16'h0005, {12'h000, chan});
    chk("divider three", 16'h0003, {14'h0000, div});
    rdc(WB_RESULT, 8'ha5, "result slow");
    $display("test reset and slow clock done");
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // adc_conversion_control_tb
